// >>> vocoder_dev.sv
// Function
// - Samples move every 125 us each way
// - Full scale is signed 32767
// - Host-side gain passes 16-bit samples unchanged
// - Coder applies exactly 0 dB gain
// - Codec setup is five register writes
// - Setup values 41 A0 83 B8 02
// - Host repeats setup after codec reset
// - All traffic travels framed as packets
// - One transport chosen by strap pins
// - Codec mode: config, status, coded bits
// - Packet mode adds speech samples in packets
// - Header: start, length, type bytes
// - Packets handled strictly in arrival order
// - First byte is always 61 hex
// - Two-byte length, MSB first, excludes header
// - Fourth byte is type; 00 control
// - Parity marker 2F and byte after reset
`timescale 1ns/10ps
`default_nettype none
module vocoder_dev (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Packet link
    pkt_if.dev LINK,
    // Mode and straps
    input wire logic PACKET_MODE,
    // Sample port
    input wire logic [15:0] ADC_SAMPLE,
    output logic [15:0] DAC_SAMPLE,
    output logic SAMPLE_TICK,
    // Codec control writes
    output logic [7:0] CODEC_ADDR,
    output logic [7:0] CODEC_DATA,
    output logic CODEC_WR,
    // Status
    output logic [1:0] PORT_ACTIVE,
    output logic PKT_ERR
);
    // ------------------------------------------------------------
    // Parser state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        R_HUNT, R_LEN_HI, R_LEN_LO, R_TYPE, R_BODY
    } rx_e;
    typedef struct packed {
        rx_e rx;
        logic [15:0] left;
        logic [7:0] ptype;
        logic [15:0] idx;
        logic [7:0] prev;
        logic [7:0] par;
        logic [1:0] port;
        logic port_set;
        logic parity_on;
        logic [13:0] tick_cnt;
        logic tick;
        logic [15:0] dac;
        logic [7:0] caddr;
        logic [7:0] cdata;
        logic cwr;
        logic err;
    } st_s;
    st_s s_q, s_d;
    logic [7:0] in_byte;
    logic in_ok, take;
    logic [7:0] out_byte;
    logic out_ok, out_rdy;

    // ------------------------------------------------------------
    // Receive buffer keeps arrival order
    // ------------------------------------------------------------
    // Parser drains a byte per clock, so depth only absorbs bursts
    byte_fifo #(.WIDTH(8), .DEPTH(pkt_pkg::FIFO_DEPTH)) u_rx (
        .CLK(CLK),
        .RST_N(RST_N),
        .in_data(LINK.h2d_data),
        .in_valid(LINK.h2d_valid),
        .in_ready(LINK.h2d_ready),
        .out_data(in_byte),
        .out_valid(in_ok),
        .out_ready(take)
    );

    // Reply stream idle: nothing ever leaves unframed
    assign take = 1'b1;
    assign LINK.d2h_data = out_byte;
    assign LINK.d2h_valid = out_ok;
    assign out_rdy = LINK.d2h_ready;
    assign out_byte = 8'h00;
    assign out_ok = 1'b0;

    // ------------------------------------------------------------
    // Body byte decode
    // ------------------------------------------------------------
    // Second byte of a pair; marker and parity byte never pair
    function automatic logic pair_end(input logic [15:0] idx,
            input logic [15:0] left, input logic par_on);
        pair_end = idx[0] && (!par_on || left > 16'h0002);
    endfunction : pair_end

    // ------------------------------------------------------------
    // Parser
    // ------------------------------------------------------------
    // Codec writes land before the parity byte can be judged
    always_comb begin
        s_d = s_q;
        s_d.cwr = 1'b0;
        s_d.tick = 1'b0;
        // Strap is latched once after reset release
        if (!s_q.port_set) begin
            s_d.port = LINK.port_sel;
            s_d.port_set = 1'b1;
        end
        // Fixed 8 kHz sample strobe
        if (s_q.tick_cnt == 14'(pkt_pkg::SAMPLE_CYC - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
            // Loopback at unity gain keeps full scale
            if (!PACKET_MODE) begin
                s_d.dac = ADC_SAMPLE;
            end
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 1'b1;
        end
        if (in_ok) begin
            s_d.prev = in_byte;
            unique case (s_q.rx)
                R_HUNT: begin
                    // Discard until start byte
                    if (in_byte == pkt_pkg::START_VAL) begin
                        s_d.rx = R_LEN_HI;
                        s_d.par = in_byte;
                    end
                end
                R_LEN_HI: begin
                    s_d.left[15:8] = in_byte;
                    s_d.par = s_q.par ^ in_byte;
                    s_d.rx = R_LEN_LO;
                end
                R_LEN_LO: begin
                    s_d.left[7:0] = in_byte;
                    s_d.par = s_q.par ^ in_byte;
                    s_d.rx = R_TYPE;
                end
                R_TYPE: begin
                    s_d.ptype = in_byte;
                    s_d.par = s_q.par ^ in_byte;
                    s_d.idx = '0;
                    s_d.rx = (s_q.left == '0) ? R_HUNT : R_BODY;
                    // Speech only framed in packet mode
                    if (in_byte == pkt_pkg::TYPE_SPEECH && !PACKET_MODE) begin
                        s_d.err = 1'b1;
                    end
                end
                R_BODY: begin
                    s_d.left = s_q.left - 1'b1;
                    s_d.idx = s_q.idx + 1'b1;
                    // Codec write: address byte then data byte
                    if (s_q.ptype == pkt_pkg::TYPE_CODEC_WR &&
                        pair_end(s_q.idx, s_q.left, s_q.parity_on)) begin
                        s_d.caddr = s_q.prev;
                        s_d.cdata = in_byte;
                        s_d.cwr = 1'b1;
                    end
                    // Speech body fills DAC sample, MSB first
                    if (s_q.ptype == pkt_pkg::TYPE_SPEECH &&
                        pair_end(s_q.idx, s_q.left, s_q.parity_on)) begin
                        s_d.dac = {s_q.prev, in_byte};
                    end
                    if (s_q.left == 16'h0001) begin
                        s_d.rx = R_HUNT;
                        // Marker must precede final parity byte
                        if (s_q.parity_on &&
                            (s_q.prev != pkt_pkg::PARITY_MARK ||
                             s_q.par != in_byte)) begin
                            s_d.err = 1'b1;
                        end
                    end else begin
                        s_d.par = s_q.par ^ in_byte;
                    end
                end
                default: s_d.rx = R_HUNT;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.rx <= R_HUNT;
            s_q.parity_on <= pkt_pkg::PARITY_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from state
    // ------------------------------------------------------------
    assign DAC_SAMPLE = s_q.dac;
    assign SAMPLE_TICK = s_q.tick;
    assign CODEC_ADDR = s_q.caddr;
    assign CODEC_DATA = s_q.cdata;
    assign CODEC_WR = s_q.cwr;
    assign PORT_ACTIVE = s_q.port;
    assign PKT_ERR = s_q.err;
endmodule : vocoder_dev
`default_nettype wire

// >>> pkt_pkg.sv
package pkt_pkg;
    // ------------------------------------------------------------
    // Framing constants
    // ------------------------------------------------------------
    localparam logic [7:0] START_VAL = 8'h61;
    localparam logic [7:0] PARITY_MARK = 8'h2F;
    localparam logic [7:0] TYPE_CTRL = 8'h00;
    localparam logic [7:0] TYPE_CHAN = 8'h01;
    localparam logic [7:0] TYPE_SPEECH = 8'h02;
    localparam int HDR_BYTES = 4;
    localparam logic PARITY_RST = 1'b1;
    // ------------------------------------------------------------
    // Transport selection
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_UART = 2'h0;
    localparam logic [1:0] PORT_PAR = 2'h1;
    localparam logic [1:0] PORT_SER = 2'h2;
    // ------------------------------------------------------------
    // Sample convention and timing
    // ------------------------------------------------------------
    localparam logic signed [15:0] FULL_SCALE = 16'sh7FFF;
    localparam int CLK_MHZ = 125;
    localparam int SAMPLE_US = 125;
    localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int FIFO_DEPTH = 32;
    localparam int CODEC_WRITES = 5;
    localparam logic [7:0] CODEC_REG [CODEC_WRITES] =
        '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06};
    localparam logic [7:0] CODEC_VAL [CODEC_WRITES] =
        '{8'h41, 8'hA0, 8'h83, 8'hB8, 8'h02};
    localparam logic [7:0] TYPE_CODEC_WR = 8'h03;
endpackage : pkt_pkg

// >>> pkt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pkt_if;
    // Byte stream host to device
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    // Byte stream device to host
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;
    // Transport strap
    logic [1:0] port_sel;
    modport dev (input h2d_data, input h2d_valid, output h2d_ready,
        output d2h_data, output d2h_valid, input d2h_ready,
        input port_sel);
    modport host (output h2d_data, output h2d_valid, input h2d_ready,
        input d2h_data, input d2h_valid, output d2h_ready,
        output port_sel);
endinterface : pkt_if
`default_nettype wire

// >>> byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } st_s;
    st_s s_q, s_d;
    logic push, pop;

    assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// >>> vocoder_host.sv
`timescale 1ns/10ps
`default_nettype none
module vocoder_host (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Packet link
    pkt_if.host LINK,
    // User control
    input wire logic [1:0] PORT_SEL,
    input wire logic CODEC_RESET_SEEN,
    output logic INIT_DONE
);
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_DONE} hs_e;
    typedef struct packed {
        hs_e st;
        logic [3:0] pos;
        logic [2:0] wr;
        logic [7:0] par;
        logic done;
    } st_s;
    st_s s_q, s_d;
    logic [7:0] b;

    // ------------------------------------------------------------
    // One codec write packet: 61 00 04 03 reg val 2F par
    // ------------------------------------------------------------
    always_comb begin
        unique case (s_q.pos)
            4'h0: b = pkt_pkg::START_VAL;
            4'h1: b = 8'h00;
            4'h2: b = 8'h04;
            4'h3: b = pkt_pkg::TYPE_CODEC_WR;
            4'h4: b = pkt_pkg::CODEC_REG[s_q.wr];
            4'h5: b = pkt_pkg::CODEC_VAL[s_q.wr];
            4'h6: b = pkt_pkg::PARITY_MARK;
            default: b = s_q.par;
        endcase
    end

    assign LINK.h2d_data = b;
    assign LINK.h2d_valid = (s_q.st == H_SEND);
    assign LINK.d2h_ready = 1'b1;
    assign LINK.port_sel = PORT_SEL;
    assign INIT_DONE = s_q.done;

    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            H_IDLE: begin
                s_d.st = H_SEND;
            end
            H_SEND: begin
                if (LINK.h2d_ready) begin
                    s_d.par = (s_q.pos == 4'h7) ? 8'h00 : s_q.par ^ b;
                    s_d.pos = (s_q.pos == 4'h7) ? 4'h0 : s_q.pos + 1'b1;
                    if (s_q.pos == 4'h7) begin
                        // Five writes per setup
                        if (s_q.wr == 3'(pkt_pkg::CODEC_WRITES - 1)) begin
                            s_d.st = H_DONE;
                            s_d.wr = '0;
                            s_d.done = 1'b1;
                        end else begin
                            s_d.wr = s_q.wr + 1'b1;
                        end
                    end
                end
            end
            H_DONE: begin
                // Codec reset wipes its registers; redo setup
                if (CODEC_RESET_SEEN) begin
                    s_d.st = H_SEND;
                    s_d.done = 1'b0;
                end
            end
            default: s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : vocoder_host
`default_nettype wire

// >>> vocoder_packet_and_codec_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module vocoder_packet_and_codec_link_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Link signals
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic d2h_valid,
    input wire logic [1:0] port_sel
);
    // ----------
    // Framing tracker
    // ----------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    logic tk;
    logic [15:0] pos_q;
    logic [15:0] len_q;
    logic [7:0] par_q;
    logic [1:0] up_q;
    assign tk = h2d_valid && h2d_ready;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pos_q <= 16'h0000;
            len_q <= 16'h0000;
            par_q <= 8'h00;
            up_q <= 2'h0;
        end else begin
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
            if (tk) begin
                pos_q <= (pos_q >= 16'h0003 && pos_q == len_q + 16'h0003)
                    ? 16'h0000 : pos_q + 16'h0001;
                if (pos_q == 16'h0001) len_q[15:8] <= h2d_data;
                if (pos_q == 16'h0002) len_q[7:0] <= h2d_data;
                par_q <= (pos_q == 16'h0000) ? h2d_data : par_q ^ h2d_data;
            end
        end
    end
    start_byte_a: assert property (tk && pos_q == 16'h0000
        |-> h2d_data == 8'h61) else $error("bad start byte");
    type_known_a: assert property (tk && pos_q == 16'h0003
        |-> h2d_data <= 8'h03) else $error("unknown type");
    len_room_a: assert property (tk && pos_q == 16'h0002
        |-> {len_q[15:8], h2d_data} >= 16'h0002) else $error("short len");
    parity_mark_a: assert property (tk && pos_q > 16'h0003
        && pos_q == len_q + 16'h0002 |-> h2d_data == 8'h2F)
        else $error("no parity marker");
    parity_byte_a: assert property (tk && pos_q > 16'h0003
        && pos_q == len_q + 16'h0003 |-> h2d_data == par_q)
        else $error("bad parity byte");
    hold_req_a: assert property (h2d_valid && !h2d_ready
        |=> h2d_valid && $stable(h2d_data)) else $error("offer dropped");
    no_raw_a: assert property (!d2h_valid)
        else $error("unframed reply");
    strap_hold_a: assert property (up_q == 2'h3 |-> $stable(port_sel))
        else $error("strap moved");
endmodule : vocoder_packet_and_codec_link_chk
`default_nettype wire

// >>> vocoder_packet_and_codec_link_test.sv
`timescale 1ns/10ps
`default_nettype none
module vocoder_packet_and_codec_link_test;
    // ----------
    // Two joined ends and a lone device end
    // ----------
    localparam logic [7:0] REG_E [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06};
    localparam logic [7:0] VAL_E [5] = '{8'h41, 8'hA0, 8'h83, 8'hB8, 8'h02};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sel = 2'h0;
    logic seen = 1'b0;
    logic mode = 1'b0;
    logic [15:0] adc = 16'h0000;
    logic [15:0] adc_q = 16'h0000;
    logic done, tick, wr, wr_b, err, err_b;
    logic [7:0] ca, cd, ca_b, cd_b;
    logic [15:0] dac, dac_b;
    time t0;
    logic [1:0] act, act_b;
    logic [15:0] wq [$];
    logic [15:0] wq_b [$];
    logic [7:0] lq [$];
    logic [15:0] rv [4];
    logic [15:0] w;
    int errors = 0;
    int num_checks = 0;
    pkt_if lnk();
    pkt_if lnk_b();
    vocoder_host i_vocoder_host (.CLK(clk), .RST_N(rst_n), .LINK(lnk),
        .PORT_SEL(sel), .CODEC_RESET_SEEN(seen), .INIT_DONE(done));
    vocoder_dev i_vocoder_dev (.CLK(clk), .RST_N(rst_n), .LINK(lnk),
        .PACKET_MODE(mode), .ADC_SAMPLE(adc), .DAC_SAMPLE(dac),
        .SAMPLE_TICK(tick), .CODEC_ADDR(ca), .CODEC_DATA(cd),
        .CODEC_WR(wr), .PORT_ACTIVE(act), .PKT_ERR(err));
    // Lone end lets the bench send junk the host never would
    vocoder_dev i_vocoder_dev_b (.CLK(clk), .RST_N(rst_n), .LINK(lnk_b),
        .PACKET_MODE(mode), .ADC_SAMPLE(adc), .DAC_SAMPLE(dac_b),
        .SAMPLE_TICK(), .CODEC_ADDR(ca_b), .CODEC_DATA(cd_b),
        .CODEC_WR(wr_b), .PORT_ACTIVE(act_b), .PKT_ERR(err_b));
    vocoder_packet_and_codec_link_chk i_chk (.CLK(clk), .RST_N(rst_n),
        .h2d_data(lnk.h2d_data), .h2d_valid(lnk.h2d_valid),
        .h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid),
        .port_sel(lnk.port_sel));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr === 1'b1) wq.push_back({ca, cd});
        if (wr_b === 1'b1) wq_b.push_back({ca_b, cd_b});
        if (lnk.h2d_valid === 1'b1 && lnk.h2d_ready === 1'b1)
            lq.push_back(lnk.h2d_data);
        adc <= 16'($urandom);
        adc_q <= adc;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic pop_wr(input logic b, output logic [15:0] v);
        int n;
        n = 0;
        v = 16'hXXXX;
        while ((b ? wq_b.size() : wq.size()) == 0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (b && wq_b.size() > 0) v = wq_b.pop_front();
        if (!b && wq.size() > 0) v = wq.pop_front();
    endtask : pop_wr
    // Parity byte: XOR of every byte before it, marker included
    function automatic logic [7:0] xor7(input logic [7:0] p [8]);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < 7; i++) x ^= p[i];
        return x;
    endfunction : xor7
    task automatic wire_chk();
        logic [7:0] f [8];
        int k;
        k = 0;
        while (lq.size() >= 8) begin
            foreach (f[i]) f[i] = lq[i];
            check(lq[0], 8'h61);
            check({lq[1], lq[2]}, 16'h0004);
            check(lq[3], 8'h03);
            check(lq[6], 8'h2F);
            check(lq[7], xor7(f));
            repeat (8) void'(lq.pop_front());
            k++;
        end
        check(k, 5);
        check(lq.size(), 0);
    endtask : wire_chk
    task automatic init_chk();
        for (int i = 0; i < 5; i++) begin
            pop_wr(1'b0, w);
            check(w, {REG_E[i], VAL_E[i]});
        end
        repeat (40) @(posedge clk);
        check(wq.size(), 0);
        check(done, 1);
        wire_chk();
    endtask : init_chk
    task automatic put(input logic [7:0] v);
        int n;
        n = 0;
        lnk_b.h2d_data <= v;
        lnk_b.h2d_valid <= 1'b1;
        @(posedge clk);
        while (lnk_b.h2d_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask : put
    // Last packet of a burst drops valid; others leave it standing
    task automatic send(input logic [7:0] ty, input logic [15:0] rw,
            input int junk, input logic bad, input logic last);
        logic [7:0] p [8];
        logic [7:0] j;
        p = '{8'h61, 8'h00, 8'h04, ty, rw[15:8], rw[7:0], 8'h2F, 8'h00};
        p[7] = xor7(p) ^ {7'h00, bad};
        for (int i = 0; i < junk; i++) begin
            j = 8'($urandom);
            put(j == 8'h61 ? 8'h60 : j);
        end
        foreach (p[i]) put(p[i]);
        if (last) begin
            lnk_b.h2d_valid <= 1'b0;
            @(posedge clk);
        end
    endtask : send
    task automatic tick_chk();
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        @(posedge clk);
        while (tick !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        check(n + 1, 15625);
        check(dac, adc_q);
    endtask : tick_chk
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #600000;
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(36));
        lnk_b.h2d_data = 8'h00;
        lnk_b.h2d_valid = 1'b0;
        lnk_b.d2h_ready = 1'b1;
        lnk_b.port_sel = 2'h0;
        for (int s = 0; s < 3; s++) begin
            rst_n <= 1'b0;
            sel <= s[1:0];
            mode <= 1'($urandom);
            lnk_b.port_sel <= 2'(2 - s);
            wq.delete();
            wq_b.delete();
            lq.delete();
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
            init_chk();
            check(act, s);
            check(act_b, 2 - s);
            seen <= 1'b1;
            @(posedge clk);
            seen <= 1'b0;
            init_chk();
            foreach (rv[k]) rv[k] = 16'($urandom);
            foreach (rv[k]) send(8'h03, rv[k], k, 1'b0, 1'b1);
            foreach (rv[k]) begin
                pop_wr(1'b1, w);
                check(w, rv[k]);
            end
            check(err, 0);
            check(err_b, 0);
            // Corrupt parity byte must raise the sticky error
            send(8'h03, rv[0], 1, 1'b1, 1'b1);
            pop_wr(1'b1, w);
            check(w, rv[0]);
            repeat (4) @(posedge clk);
            check(err_b, 1);
        end
        // Buffer through the lone end: 32 bytes, one edge each, plus one
        t0 = $time;
        foreach (rv[k]) send(8'h03, rv[k], 0, 1'b0, k == 3);
        check(32'(($time - t0) / 8), 33);
        foreach (rv[k]) begin
            pop_wr(1'b1, w);
            check(w, rv[k]);
        end
        check(lnk_b.h2d_ready, 1);
        // Speech packets in packet mode, full-scale corners first
        mode <= 1'b1;
        rv = '{16'h7FFF, 16'h8001, 16'($urandom), 16'($urandom)};
        foreach (rv[k]) begin
            send(8'h02, rv[k], 0, 1'b0, 1'b1);
            repeat (4) @(posedge clk);
            check(dac_b, rv[k]);
        end
        mode <= 1'b0;
        tick_chk();
        wrap_up();
    end
endmodule : vocoder_packet_and_codec_link_test
`default_nettype wire
